// *** cpu_core_model.sv ***
`timescale 1ns/1ps
// Processor core stand-in: takes a shown request, then returns from the handler.
module cpu_core_model (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Request side.
  input  wire logic       service,
  input  wire logic       cpu_irq,
  input  wire logic       entry_done,
  input  wire logic       return_done,
  output logic            cpu_ack,
  output logic            cpu_return,
  // Measured latencies.
  output logic [3:0]      entry_lat,
  output logic [3:0]      ret_lat
);
  logic       busy;
  logic [3:0] cnt;
  // One ack per request, held for a single edge so it is never taken twice.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {cpu_ack, cpu_return, busy, cnt, entry_lat, ret_lat} <= '0;
    end else begin
      cnt <= cnt + 4'h1;
      cpu_ack <= service & cpu_irq & ~busy & ~cpu_ack;
      cpu_return <= entry_done;
      if (cpu_ack) begin
        busy <= 1'b1;
        cnt <= 4'h0;
      end
      if (cpu_return) cnt <= 4'h0;
      if (entry_done) entry_lat <= cnt;
      if (return_done) begin
        ret_lat <= cnt;
        busy <= 1'b0;
      end
    end
  end
endmodule

// *** interrupt_vector_priority_unit.sv ***
`timescale 1ns/1ps
`include "ivpu_consts.svh"
// Summary of operation
// RQ1 - Merge all peripheral requests into one request.
// RQ2 - Six traps plus 118 sources, distinct vectors.
// RQ3 - Seven priority levels, fixed order within level.
// RQ4 - Lower vector address wins ties.
// RQ5 - Fixed entry and return cycle counts.
// RQ6 - Primary table starts at word 000004h.
// RQ7 - Vector entries are 24-bit handler addresses.
// RQ8 - Trap vectors ordered from 000004h upward.
// RQ9 - Interrupt vectors 000014h to 0000FEh, stride two.
// RQ10 - Alternate select bit redirects all vector fetches. The code redirects them only while boot_segment_present is also set.
// RQ11 - Alternate table mirrors primary layout from base.
// RQ12 - Alternate base is last boot page start.
// RQ13 - Reset bypasses controller, execution at zero.
// RQ14 - Reset jump at 000000h, target at 000002h.
// RQ15 - Alternate base equals final boot page start.
// RQ16 - Forward only above CPU priority; traps first.
module interrupt_vector_priority_unit (
  // Clock and reset.
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // Peripheral request flags, enables and user levels.
  input  wire logic [`NUM_IRQ-1:0]         irq_pending,
  input  wire logic [`NUM_IRQ-1:0]         irq_enable,
  input  wire logic [`NUM_IRQ*3-1:0]       irq_level,
  input  wire logic [`NUM_TRAP-1:0]        trap_pending,
  // Control bits and boot segment description.
  input  wire logic [15:0]                 interrupt_control_reg_b,
  input  wire logic                        boot_segment_present,
  input  wire logic [23:0]                 boot_page_base_offset,
  // Processor core handshake.
  input  wire logic [3:0]                  cpu_priority,
  input  wire logic                        cpu_ack,
  input  wire logic                        cpu_return,
  output logic                             cpu_irq,
  output ivpu_pkg::cpu_request_s           cpu_req,
  output logic                             entry_done,
  output logic                             return_done,
  output logic [23:0]                      reset_vector
);

  // Slot address in a table: base plus two words per slot.
  function automatic logic [23:0] slot_addr(input logic [23:0] base, input logic [6:0] idx);
    slot_addr = base + {16'h0000, idx, 1'b0};
  endfunction

  // Alternate table only usable when a boot segment exists.
  wire        alt_active = interrupt_control_reg_b[`ALT_TABLE_SELECT_BIT] & boot_segment_present; // RQ10 RQ12
  wire [23:0] table_base = alt_active ? boot_page_base_offset : `PRIMARY_TABLE_BASE; // RQ11 RQ15

  // Trap selection: lowest index wins; reserved slots 5 and 7 never raise.
  // Filtering here keeps a stray reserved flag from stealing the core.
  logic       trap_any;
  logic [2:0] trap_idx;
  always_comb begin
    trap_any = 1'b0;
    trap_idx = 3'h0;
    for (int t = `NUM_TRAP - 1; t >= 0; t--) begin
      if (trap_pending[t] && t != `RSVD_TRAP_LOW && t != `RSVD_TRAP_HIGH) begin // RQ2 RQ8
        trap_any = 1'b1;
        trap_idx = t[2:0];
      end
    end
  end

  // Interrupt selection: higher level wins, lower index wins ties.
  logic       irq_any;
  logic [6:0] irq_idx;
  logic [2:0] irq_best;
  always_comb begin
    irq_any  = 1'b0;
    irq_idx  = 7'h00;
    irq_best = 3'h0;
    for (int i = 0; i < `NUM_IRQ; i++) begin
      if (irq_pending[i] && irq_enable[i] && irq_level[i*3 +: 3] != 3'h0 &&
          irq_level[i*3 +: 3] > irq_best) begin // RQ3 RQ4
        irq_any  = 1'b1;
        irq_idx  = i[6:0];
        irq_best = irq_level[i*3 +: 3];
      end
    end
  end

  // Only forward an interrupt that beats the current CPU level.
  wire irq_ok   = irq_any && ({1'b0, irq_best} > cpu_priority); // RQ16
  wire want     = trap_any || irq_ok; // RQ1
  wire [23:0] trap_vec = slot_addr(table_base + `TRAP_TABLE_BASE, {4'h0, trap_idx}); // RQ6 RQ8
  wire [23:0] irq_vec  = slot_addr(table_base + `IRQ_TABLE_BASE, irq_idx); // RQ9 RQ11

  ivpu_pkg::cpu_request_s req_next;
  always_comb begin
    req_next.valid       = want;
    req_next.is_trap     = trap_any; // RQ16
    req_next.index       = trap_any ? {4'h0, trap_idx} : irq_idx;
    req_next.level       = trap_any ? `TRAP_PRIORITY : {1'b0, irq_best};
    req_next.vector_addr = trap_any ? trap_vec : irq_vec; // RQ7
  end

  // Sequencer with fixed entry and return latencies.
  ivpu_pkg::ctrl_state_e state_reg;
  logic [2:0]            count_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= ivpu_pkg::st_idle;
      count_reg   <= 3'h0;
      cpu_irq     <= 1'b0;
      cpu_req     <= '0;
      entry_done  <= 1'b0;
      return_done <= 1'b0;
    end else begin
      entry_done  <= 1'b0;
      return_done <= 1'b0;
      case (state_reg)
        ivpu_pkg::st_idle: begin
          cpu_irq <= want;
          cpu_req <= req_next;
          // Ack is matched against the live request, so a withdrawn source is never entered.
          if (want && cpu_ack) begin
            state_reg <= ivpu_pkg::st_entry;
            count_reg <= `ENTRY_CYCLES - 3'h1; // RQ5
            cpu_irq   <= 1'b0;
          end
        end
        ivpu_pkg::st_entry: begin
          if (count_reg == 3'h0) begin
            entry_done <= 1'b1; // RQ5
            state_reg  <= ivpu_pkg::st_fetch;
          end else begin
            count_reg <= count_reg - 3'h1;
          end
        end
        ivpu_pkg::st_fetch: begin
          // Handler runs; a return starts the fixed return latency.
          if (cpu_return) begin
            state_reg <= ivpu_pkg::st_return;
            count_reg <= `RETURN_CYCLES - 3'h1; // RQ5
          end
        end
        ivpu_pkg::st_return: begin
          if (count_reg == 3'h0) begin
            return_done <= 1'b1;
            state_reg   <= ivpu_pkg::st_idle;
          end else begin
            count_reg <= count_reg - 3'h1;
          end
        end
        default: state_reg <= ivpu_pkg::st_idle;
      endcase
    end
  end

  // Reset never goes through the arbiter; the core starts at the jump slot.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reset_vector <= `RESET_GOTO_ADDR; // RQ13 RQ14
    end else begin
      reset_vector <= `RESET_GOTO_ADDR; // RQ13
    end
  end

  // Checks.
  // Done pulses register on the last count edge, so they are sampled one edge later.
  entry_fixed_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ5
    (state_reg == ivpu_pkg::st_idle && want && cpu_ack) |-> ##4 entry_done)
    else $error("entry latency wrong");
  return_fixed_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ5
    (state_reg == ivpu_pkg::st_fetch && cpu_return) |-> ##3 return_done)
    else $error("return latency wrong");
  trap_first_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ16
    (state_reg == ivpu_pkg::st_idle && trap_any && !cpu_ack) |=> (cpu_req.is_trap && cpu_irq))
    else $error("trap not preferred");
  merge_req_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ1
    (state_reg == ivpu_pkg::st_idle && !cpu_ack) |=> (cpu_irq == $past(want)))
    else $error("merged request mismatch");
  mask_level_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ16
    (cpu_irq && !cpu_req.is_trap) |-> (cpu_req.level > $past(cpu_priority)))
    else $error("interrupt below cpu level");
  vec_range_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ9
    (cpu_irq && !cpu_req.is_trap && !$past(alt_active)) |->
    (cpu_req.vector_addr >= `IRQ_TABLE_BASE && cpu_req.vector_addr <= `IRQ_LAST_ADDR))
    else $error("interrupt vector out of table");
  trap_range_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ8
    (cpu_irq && cpu_req.is_trap && !$past(alt_active)) |->
    (cpu_req.vector_addr >= `TRAP_TABLE_BASE && cpu_req.vector_addr < `IRQ_TABLE_BASE))
    else $error("trap vector out of table");
  alt_base_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ10
    (cpu_irq && $past(alt_active) && !cpu_req.is_trap) |->
    (cpu_req.vector_addr == $past(boot_page_base_offset) + `IRQ_TABLE_BASE + {16'h0, cpu_req.index, 1'b0}))
    else $error("alternate vector wrong");
  reset_zero_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ13
    reset_vector == `RESET_GOTO_ADDR)
    else $error("reset vector not zero");
  // The merged request always carries its valid flag.
  req_valid_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ1
    cpu_irq |-> cpu_req.valid)
    else $error("request shown without valid");
  // Traps are shown above every user level.
  trap_level_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ16
    (cpu_irq && cpu_req.is_trap) |-> (cpu_req.level == `TRAP_PRIORITY))
    else $error("trap level wrong");
  // Reserved trap slots must never reach the core.
  trap_rsvd_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ8
    (cpu_irq && cpu_req.is_trap) |-> (cpu_req.index != `RSVD_TRAP_LOW && cpu_req.index != `RSVD_TRAP_HIGH))
    else $error("reserved trap forwarded");
  // Oscillator fail holds the lowest slot and beats every other trap.
  trap_order_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ4
    (cpu_irq && $past(trap_pending[0])) |-> (cpu_req.is_trap && cpu_req.index == 7'h00))
    else $error("trap order wrong");
  // While a request is being serviced no second one is raised.
  busy_quiet_a: assert property (@(posedge clock) disable iff (!reset_n) // RQ5
    (state_reg != ivpu_pkg::st_idle) |-> !cpu_irq)
    else $error("request raised during service");
  // Main scenarios.
  cover_trap_c: cover property (@(posedge clock) disable iff (!reset_n) cpu_irq && cpu_req.is_trap);
  cover_alt_c: cover property (@(posedge clock) disable iff (!reset_n) cpu_irq && alt_active);
  cover_entry_c: cover property (@(posedge clock) disable iff (!reset_n) entry_done);
  cover_ret_c: cover property (@(posedge clock) disable iff (!reset_n) return_done);
  cover_mask_c: cover property (@(posedge clock) disable iff (!reset_n) irq_any && !irq_ok);

endmodule

// *** interrupt_vector_priority_unit_bench.sv ***
`timescale 1ns/1ps
`include "ivpu_consts.svh"
module interrupt_vector_priority_unit_bench;
  logic clock = 0, reset_n = 0, service = 0, ack, ret, irq, edone, rdone, bootp = 0;
  logic [117:0] pend = '0, en = '0;
  logic [353:0] lvl = '0;
  logic [7:0] trap = '0;
  logic [15:0] ctrl = '0;
  logic [23:0] base = 24'h00F000, rvec;
  logic [3:0] cprio = '0, elat, rlat;
  ivpu_pkg::cpu_request_s req;
  int err_count = 0, tests_run = 0, cycles = 0;
  interrupt_vector_priority_unit i_interrupt_vector_priority_unit (.clock(clock), .reset_n(reset_n),
    .irq_pending(pend), .irq_enable(en), .irq_level(lvl), .trap_pending(trap), .interrupt_control_reg_b(ctrl),
    .boot_segment_present(bootp), .boot_page_base_offset(base), .cpu_priority(cprio), .cpu_ack(ack),
    .cpu_return(ret), .cpu_irq(irq), .cpu_req(req), .entry_done(edone), .return_done(rdone), .reset_vector(rvec));
  cpu_core_model i_cpu_core_model (.clock(clock), .reset_n(reset_n), .service(service), .cpu_irq(irq),
    .entry_done(edone), .return_done(rdone), .cpu_ack(ack), .cpu_return(ret), .entry_lat(elat), .ret_lat(rlat));
  // Free-running clock at 250 MHz.
  always #2 clock = ~clock;
  // A hang is cut short well beyond the length of all scenarios.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      conclude();
    end
  end
  task conclude();
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Compares a settled value with the expected one.
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Raises one source; the result is looked at after the registered outputs settle.
  task src(input int i, input logic [2:0] lv);
    @(posedge clock);
    pend[i] <= 1'b1;
    en[i] <= 1'b1;
    lvl[i*3+:3] <= lv;
  endtask
  task settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task t_reset();
    chk("reset_vector", 24'h000000, rvec);
    chk("cpu_irq", 24'h0, irq);
  endtask
  // Ties go to the lower slot; a higher user level beats position.
  task t_prio();
    src(5, 3'h3);
    src(2, 3'h3);
    settle();
    chk("tie vector", 24'h000018, req.vector_addr);
    @(posedge clock) {pend[0], lvl[2:0]} <= {1'b1, 3'h7};
    settle();
    chk("disabled source", 24'h000018, req.vector_addr);
    src(117, 3'h7);
    settle();
    chk("level vector", 24'h0000FE, req.vector_addr);
    chk("merged request", 24'h1, irq);
    chk("request valid", 24'h1, req.valid);
    chk("level index", 24'h000075, req.index);
    chk("level value", 24'h000007, req.level);
    @(posedge clock) cprio <= 4'h7;
    settle();
    chk("masked by cpu level", 24'h0, irq);
  endtask
  // Traps override the mask; reserved slot 5 is ignored.
  task t_trap();
    @(posedge clock) trap <= 8'h01;
    settle();
    chk("osc fail vector", 24'h000004, req.vector_addr);
    chk("trap flag", 24'h1, req.is_trap);
    chk("trap level", {20'h0, `TRAP_PRIORITY}, req.level);
    @(posedge clock) trap <= 8'h40;
    settle();
    chk("soft trap vector", 24'h000010, req.vector_addr);
    @(posedge clock) {trap, cprio} <= {8'h20, 4'h0};
    settle();
    chk("reserved trap", 24'h0000FE, req.vector_addr);
  endtask
  // The alternate table only exists alongside a boot segment.
  task t_alt();
    @(posedge clock) {ctrl[8], bootp, trap} <= {2'b11, 8'h01};
    settle();
    chk("alt trap vector", 24'h00F004, req.vector_addr);
    @(posedge clock) trap <= 8'h00;
    settle();
    chk("alt vector", 24'h00F0FE, req.vector_addr);
    @(posedge clock) bootp <= 1'b0;
    settle();
    chk("no boot segment", 24'h0000FE, req.vector_addr);
    @(posedge clock) ctrl[8] <= 1'b0;
  endtask
  // Entry and return counts are measured by the core model.
  task t_service();
    @(posedge clock) service <= 1'b1;
    repeat (14) @(posedge clock);
    service <= 1'b0;
    repeat (12) @(posedge clock);
    #1;
    chk("entry cycles", {21'h0, `ENTRY_CYCLES}, {20'h0, elat});
    chk("return cycles", {21'h0, `RETURN_CYCLES}, {20'h0, rlat});
  endtask
  // A reset in mid-run clears the shown request at once; sources are dropped with it.
  task t_rerun();
    @(posedge clock) {reset_n, pend} <= {1'b0, 118'h0};
    #1;
    chk("irq in reset", 24'h0, irq);
    chk("valid in reset", 24'h0, req.valid);
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
    chk("irq after reset", 24'h0, irq);
    chk("vector after reset", 24'h000000, rvec);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_prio();
    t_trap();
    t_alt();
    t_service();
    t_rerun();
    conclude();
  end
endmodule

// *** ivpu_consts.svh ***
`ifndef IVPU_CONSTS_SVH
`define IVPU_CONSTS_SVH
// Vector table layout, in program memory word addresses.
`define RESET_GOTO_ADDR      24'h000000
`define RESET_TARGET_ADDR    24'h000002
`define TRAP_TABLE_BASE      24'h000004
`define IRQ_TABLE_BASE       24'h000014
`define IRQ_LAST_ADDR        24'h0000FE
`define PRIMARY_TABLE_BASE   24'h000000
`define RSVD_TRAP_LOW        5
`define RSVD_TRAP_HIGH       7
`define VECTOR_SLOT_STRIDE   24'h000002
`define NUM_IRQ              118
`define NUM_TRAP             8
`define IRQ_INDEX_W          7
`define TRAP_INDEX_W         3
`define PRIO_W               3
`define ADDR_W               24
`define TRAP_PRIORITY        4'h8
// Control bit positions.
`define ALT_TABLE_SELECT_BIT 8
// Fixed entry and return latencies in clock cycles.
`define ENTRY_CYCLES         3'h3
`define RETURN_CYCLES        3'h2
`endif

// *** ivpu_pkg.sv ***
package ivpu_pkg;
  typedef enum logic [1:0] {st_idle, st_fetch, st_entry, st_return} ctrl_state_e;
  // Request handed to the processor core.
  typedef struct packed {
    logic        valid;
    logic        is_trap;
    logic [6:0]  index;
    logic [3:0]  level;
    logic [23:0] vector_addr;
  } cpu_request_s;
endpackage
